// [sim/bbd_core_test.sv]
// self-checking bench for the decoder core: one preloaded program walks every instruction group
// assumes bbd_pkg is compiled first; the memory model answers combinationally
`timescale 1ns/10ps
`default_nettype none
module bbd_core_test;
   import bbd_pkg::*;
   typedef struct {bbd_addr_t pc; logic z; logic c; logic ill; int cyc;} bbd_exp_s;
   logic clk_in, rst_n_in, watchdog_sel_in, wake_in, ds_we_out, zero_out, carry_out;
   logic done_out, illegal_out, wait_out, stop_out;
   logic [1:0] return_from_interrupt_flags_in;
   logic [7:0] pm_data_in, ds_addr_out, ds_rdata_in, ds_wdata_out, r1, r2;
   logic [2:0] b1, b2;
   bbd_addr_t pm_addr_out, pc_out;
   bbd_exp_s exq[$];
   bbd_exp_s e;
   logic [15:0] wrq[$];
   int err_count = 0;
   int checks_done = 0;
   int cyc = 0;
   int last_done = -1;

   bbd_core bbd_core_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .pm_addr_out(pm_addr_out),
      .pm_data_in(pm_data_in), .ds_addr_out(ds_addr_out), .ds_rdata_in(ds_rdata_in),
      .ds_wdata_out(ds_wdata_out), .ds_we_out(ds_we_out), .watchdog_sel_in(watchdog_sel_in),
      .return_from_interrupt_flags_in(return_from_interrupt_flags_in), .wake_in(wake_in), .pc_out(pc_out), .zero_out(zero_out),
      .carry_out(carry_out), .done_out(done_out), .illegal_out(illegal_out), .wait_out(wait_out),
      .stop_out(stop_out));
   bbd_mem_model bbd_mem_model_inst (.clk_in(clk_in), .pm_addr_in(pm_addr_out), .pm_data_out(pm_data_in),
      .ds_addr_in(ds_addr_out), .ds_rdata_out(ds_rdata_in), .ds_wdata_in(ds_wdata_out), .ds_we_in(ds_we_out));

   initial begin
      clk_in = 1'b0;
      forever #2.5 clk_in = ~clk_in;
   end
   always @(posedge clk_in) cyc <= cyc + 1;

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic cmp_word(input logic [15:0] got, input logic [15:0] want);
      checks_done++;
      if (got !== want) begin
         err_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, want);
      end
   endtask
   task automatic cmp_bit(input logic got, input logic want);
      cmp_word({15'h0000, got}, {15'h0000, want});
   endtask
   task automatic ex(input bbd_addr_t pc, input logic z, input logic c, input logic ill, input int n);
      exq.push_back('{pc, z, c, ill, n});
   endtask
   task automatic ld(input bbd_addr_t a, input logic [7:0] x, input logic [7:0] y, input logic [7:0] w);
      bbd_mem_model_inst.prog[a] = x;
      bbd_mem_model_inst.prog[a + 12'h001] = y;
      bbd_mem_model_inst.prog[a + 12'h002] = w;
   endtask
   function automatic logic [7:0] bop(input logic [2:0] i, input logic pol, input logic [3:0] col);
      return {i[0], i[1], i[2], pol, col};
   endfunction
   function automatic logic [7:0] rel(input logic [4:0] d, input logic [1:0] cd);
      return {d, cd, 1'b0};
   endfunction

   // completions and writes are judged off the launching edge, once the registers have settled
   always @(negedge clk_in) begin
      if (rst_n_in === 1'b1 && done_out === 1'b1) begin
         if (exq.size() == 0) begin
            cmp_bit(done_out, 1'b0);
         end else begin
            e = exq.pop_front();
            cmp_word({4'h0, pc_out}, {4'h0, e.pc});
            cmp_bit(zero_out, e.z);
            cmp_bit(carry_out, e.c);
            cmp_bit(illegal_out, e.ill);
            if (e.cyc != 0 && last_done >= 0) begin
               cmp_word(16'(cyc - last_done), 16'(e.cyc));
            end
         end
         last_done = cyc;
      end
      if (rst_n_in === 1'b1 && ds_we_out === 1'b1) begin
         if (wrq.size() == 0) begin
            cmp_bit(ds_we_out, 1'b0);
         end else begin
            cmp_word({ds_addr_out, ds_wdata_out}, wrq.pop_front());
         end
      end
   end

   task automatic halt_check(input logic want_wait, input logic want_stop);
      int n;
      n = 0;
      while (wait_out !== 1'b1 && stop_out !== 1'b1 && n < 100) begin
         @(posedge clk_in);
         #1 n++;
      end
      if (n >= 100) begin
         cmp_bit(1'b1, 1'b0);
         conclude();
      end else begin
         cmp_bit(wait_out, want_wait);
         cmp_bit(stop_out, want_stop);
         $display("halt state checked at %0t", $time);
      end
   endtask
   task automatic wake_up();
      wake_in = 1'b1;
      @(posedge clk_in);
      #1 wake_in = 1'b0;
      cmp_bit(wait_out | stop_out, 1'b0);
   endtask

   initial begin
      rst_n_in = 1'b0;
      watchdog_sel_in = 1'b0;
      wake_in = 1'b0;
      void'($urandom(13));
      r1 = 8'($urandom());
      r2 = 8'($urandom());
      b1 = 3'($urandom());
      b2 = 3'($urandom());
      return_from_interrupt_flags_in = 2'($urandom());
      for (int i = 0; i < 4096; i++) bbd_mem_model_inst.prog[i] = 8'h2D;
      bbd_mem_model_inst.data[8'h40] = r1;
      bbd_mem_model_inst.data[8'h41] = r2;
      // loaded in rising address order so padding bytes are overwritten by later instructions
      ld(12'h000, rel(5'h03, 2'b00), 8'h2D, 8'h2D);
      ld(12'h004, rel(5'h05, 2'b10), 8'h2D, 8'h2D);
      ld(12'h005, bop(b1, 1'b1, 4'hB), 8'h40, 8'h2D);
      ld(12'h007, bop(b1, 1'b1, 4'h3), 8'h40, 8'h7F);
      ld(12'h079, bop(b1, 1'b0, 4'hB), 8'h40, 8'h2D);
      ld(12'h07B, bop(b1, 1'b1, 4'h3), 8'h40, 8'h80);
      ld(12'h07E, rel(5'h0F, 2'b01), 8'h2D, 8'h2D);
      ld(12'h088, rel(5'h10, 2'b11), 8'h2D, 8'h2D);
      ld(12'h08E, 8'h51, 8'hA3, 8'h2D);
      ld(12'h090, 8'h4D, 8'h2D, 8'h2D);
      ld(12'h091, 8'hF9, 8'hF0, 8'h2D);
      ld(12'h525, 8'hCD, 8'h2D, 8'h2D);
      ld(12'h5A3, bop(b2, 1'b0, 4'h3), 8'h41, 8'h80);
      ld(12'h5A6, 8'hCD, 8'h2D, 8'h2D);
      ld(12'hFF0, 8'h2D, 8'h0F, 8'h6D);
      ld(12'hFF3, 8'hED, 8'h6D, 8'h2D);
      ex(12'h004, 1'b0, 1'b0, 1'b0, 2);
      ex(12'h005, 1'b0, 1'b0, 1'b0, 2);
      ex(12'h007, 1'b0, 1'b0, 1'b0, 4);
      wrq.push_back({8'h40, r1 | (8'h01 << b1)});
      ex(12'h088, 1'b0, 1'b1, 1'b0, 5);
      ex(12'h079, 1'b0, 1'b1, 1'b0, 2);
      ex(12'h07B, 1'b0, 1'b1, 1'b0, 4);
      wrq.push_back({8'h40, r1 & ~(8'h01 << b1)});
      ex(12'h07E, 1'b0, 1'b0, 1'b0, 5);
      ex(12'h08E, 1'b0, 1'b0, 1'b0, 2);
      ex(12'h5A3, 1'b0, 1'b0, 1'b0, 4);
      ex(r2[b2] ? 12'h5A6 : 12'h525, 1'b0, r2[b2], 1'b0, 5);
      ex(12'h090, 1'b0, r2[b2], 1'b0, 2);
      ex(12'h091, return_from_interrupt_flags_in[0], return_from_interrupt_flags_in[1], 1'b0, 2);
      ex(12'hFF0, return_from_interrupt_flags_in[0], return_from_interrupt_flags_in[1], 1'b0, 4);
      ex(12'hFF1, return_from_interrupt_flags_in[0], return_from_interrupt_flags_in[1], 1'b0, 2);
      ex(12'hFF2, return_from_interrupt_flags_in[0], return_from_interrupt_flags_in[1], 1'b1, 2);
      ex(12'hFF3, return_from_interrupt_flags_in[0], return_from_interrupt_flags_in[1], 1'b0, 2);
      ex(12'hFF4, return_from_interrupt_flags_in[0], return_from_interrupt_flags_in[1], 1'b0, 0);
      ex(12'hFF5, return_from_interrupt_flags_in[0], return_from_interrupt_flags_in[1], 1'b0, 0);
      repeat (3) @(posedge clk_in);
      #1 rst_n_in = 1'b1;
      halt_check(1'b0, 1'b1);
      wake_up();
      halt_check(1'b1, 1'b0);
      watchdog_sel_in = 1'b1;
      wake_up();
      halt_check(1'b1, 1'b0);
      for (int n = 0; n < 20 && exq.size() != 0; n++) @(posedge clk_in);
      cmp_word(16'(exq.size() + wrq.size()), 16'h0000);
      $display("program run finished at %0t", $time);
      conclude();
   end
endmodule // bbd_core_test
`default_nettype wire

// [sim/bbd_mem_model.sv]
// program memory and data space that stand around the decoder core
// assumes asynchronous read; the bench preloads both arrays before reset is released
`timescale 1ns/10ps
`default_nettype none
module bbd_mem_model (
   // clock
   input wire logic clk_in,
   // program side
   input wire logic [11:0] pm_addr_in,
   output logic [7:0] pm_data_out,
   // data side
   input wire logic [7:0] ds_addr_in,
   output logic [7:0] ds_rdata_out,
   input wire logic [7:0] ds_wdata_in,
   input wire logic ds_we_in
);
   logic [7:0] prog [4096];
   logic [7:0] data [256];
   assign pm_data_out = prog[pm_addr_in];
   assign ds_rdata_out = data[ds_addr_in];
   // only plain bytes are modelled, so bit set/clear never meets port or mixed-access registers
   always @(posedge clk_in) begin
      if (ds_we_in === 1'b1) begin
         data[ds_addr_in] <= ds_wdata_in;
      end
   end
endmodule // bbd_mem_model
`default_nettype wire

// [src/bbd_bit_if.sv]
// carrier between the core and its bit unit
// assumes both ends run combinationally within one clk_in cycle
`timescale 1ns/10ps
`default_nettype none
interface bbd_bit_if;
   logic [7:0] data;
   logic [2:0] idx;
   logic set_mode;
   logic [7:0] result;
   logic tested;
   modport core (output data, idx, set_mode, input result, tested);
   modport unit (input data, idx, set_mode, output result, tested);
endinterface // bbd_bit_if
`default_nettype wire

// [src/bbd_bit_unit.sv]
// bit select, test and modify on one data-space byte
// assumes the core holds data and idx steady while it samples the answers
`timescale 1ns/10ps
`default_nettype none
module bbd_bit_unit (
   bbd_bit_if.unit bus
);
   genvar g;

   // each bit is either passed or forced, so only the selected one can change
   generate
      for (g = 0; g < 8; g++) begin : g_bit
         assign bus.result[g] = (bus.idx == 3'(g)) ? bus.set_mode : bus.data[g];
      end
   endgenerate

   assign bus.tested = bus.data[bus.idx];

endmodule // bbd_bit_unit
`default_nettype wire

// [src/bbd_core.sv]
// sequencer for relative branches, bit test-and-branch, bit set/clear, jump/call and control ops
// assumes asynchronous-read program memory and data space: data returns in the cycle of the address
`timescale 1ns/10ps
`default_nettype none
`include "bbd_defines.svh"

module bbd_core (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // program memory
   output bbd_pkg::bbd_addr_t pm_addr_out,
   input wire logic [7:0] pm_data_in,
   // data space
   output logic [7:0] ds_addr_out,
   input wire logic [7:0] ds_rdata_in,
   output logic [7:0] ds_wdata_out,
   output logic ds_we_out,
   // system
   input wire logic watchdog_sel_in,
   input wire logic [1:0] return_from_interrupt_flags_in,
   input wire logic wake_in,
   // status
   output bbd_pkg::bbd_addr_t pc_out,
   output logic zero_out,
   output logic carry_out,
   output logic done_out,
   output logic illegal_out,
   output logic wait_out,
   output logic stop_out
);
   import bbd_pkg::*;

   bbd_phase_e phase;
   bbd_class_e cls;
   bbd_class_e first_cls;
   bbd_addr_t pc;
   bbd_addr_t next_pc;
   bbd_addr_t stack [0:`BBD_STACK_DEPTH-1];
   logic [2:0] sp;
   logic [7:0] opcode;
   logic [7:0] disp;
   logic zero;
   logic carry;
   logic taken;
   logic rel_cond;
   logic [2:0] cyc;
   bbd_bit_if bit_bus ();

   function automatic bbd_class_e decode(input logic [7:0] op);
      bbd_class_e r;
      r = BBD_CL_OTHER;
      if (!op[0]) r = BBD_CL_REL;
      else if (op[3:0] == `BBD_COL_CALL) r = BBD_CL_CALL;
      else if (op[3:0] == `BBD_COL_JUMP) r = BBD_CL_JUMP;
      else if (op[3:0] == `BBD_COL_BTST) r = BBD_CL_BTST;
      else if (op[3:0] == `BBD_COL_BITOP) r = BBD_CL_BITOP;
      else if (op == `BBD_OP_NOP) r = BBD_CL_NOP;
      else if (op == `BBD_OP_RET) r = BBD_CL_RET;
      else if (op == `BBD_OP_RETURN_FROM_INTERRUPT) r = BBD_CL_RETURN_FROM_INTERRUPT;
      else if (op == `BBD_OP_STOP) r = BBD_CL_STOP;
      else if (op == `BBD_OP_WAIT) r = BBD_CL_WAIT;
      return r;
   endfunction

   assign cls = decode(opcode);
   assign first_cls = decode(pm_data_in);

   // bit index is the bit-reversed upper three opcode bits
   assign bit_bus.data = ds_rdata_in;
   assign bit_bus.idx = {opcode[5], opcode[6], opcode[7]};
   assign bit_bus.set_mode = opcode[`BBD_POL_BIT];

   bbd_bit_unit u_bit (
      .bus(bit_bus.unit)
   );

   // bit 1 picks carry or zero, bit 2 the wanted level
   assign rel_cond = ((opcode[`BBD_REL_SEL_BIT] ? carry : zero) == opcode[`BBD_REL_WANT_BIT]);

   always_comb begin
      next_pc = pc + `BBD_LEN_REL;
      case (cls)
         BBD_CL_REL: begin
            // two's complement e plus one gives -15..+16 from the branch itself
            if (rel_cond) next_pc = pc + {{7{opcode[7]}}, opcode[7:3]} + `BBD_LEN_REL;
            else next_pc = pc + `BBD_LEN_REL;
         end
         BBD_CL_BTST: begin
            if (taken) next_pc = pc + {{4{disp[7]}}, disp} + `BBD_LEN_EXT;
            else next_pc = pc + `BBD_LEN_BTST;
         end
         BBD_CL_BITOP: next_pc = pc + `BBD_LEN_EXT;
         BBD_CL_JUMP, BBD_CL_CALL: next_pc = {opcode[7:4], ds_addr_out};
         BBD_CL_RET, BBD_CL_RETURN_FROM_INTERRUPT: next_pc = (sp == 3'd0) ? pc + `BBD_LEN_REL : stack[sp - 3'd1];
         default: next_pc = pc + `BBD_LEN_REL;
      endcase
   end

   // sequencing: one phase per cycle, lengths fixed by class
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         phase <= BBD_PH_OP;
      end else begin
         case (phase)
            BBD_PH_OP: begin
               if (first_cls == BBD_CL_REL || first_cls == BBD_CL_NOP || first_cls == BBD_CL_RET ||
                   first_cls == BBD_CL_RETURN_FROM_INTERRUPT || first_cls == BBD_CL_STOP || first_cls == BBD_CL_WAIT ||
                   first_cls == BBD_CL_OTHER) begin
                  phase <= BBD_PH_END;
               end else begin
                  phase <= BBD_PH_B2;
               end
            end
            BBD_PH_B2: phase <= BBD_PH_MEM;
            BBD_PH_MEM: phase <= (cls == BBD_CL_BTST) ? BBD_PH_B3 : BBD_PH_END;
            BBD_PH_B3: phase <= BBD_PH_END;
            BBD_PH_END: begin
               if (cls == BBD_CL_STOP || cls == BBD_CL_WAIT) phase <= BBD_PH_HALT;
               else phase <= BBD_PH_OP;
            end
            BBD_PH_HALT: if (wake_in) phase <= BBD_PH_OP;
            default: phase <= BBD_PH_OP;
         endcase
      end
   end

   // instruction bytes
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         opcode <= 8'h00;
         disp <= 8'h00;
         ds_addr_out <= 8'h00;
      end else begin
         if (phase == BBD_PH_OP) opcode <= pm_data_in;
         if (phase == BBD_PH_B2) ds_addr_out <= pm_data_in;
         if (phase == BBD_PH_B3) disp <= pm_data_in;
      end
   end

   // program counter and fetch address
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         pc <= `BBD_RESET_PC;
         pm_addr_out <= `BBD_RESET_PC;
      end else begin
         case (phase)
            BBD_PH_OP: pm_addr_out <= pc + `BBD_LEN_REL;
            BBD_PH_B2: pm_addr_out <= pc + `BBD_LEN_EXT;
            BBD_PH_END: begin
               pc <= next_pc;
               pm_addr_out <= next_pc;
            end
            default: pm_addr_out <= pm_addr_out;
         endcase
      end
   end

   // flags: only bit test and interrupt return write them
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         zero <= 1'b0;
         carry <= 1'b0;
         taken <= 1'b0;
      end else begin
         if (phase == BBD_PH_MEM && cls == BBD_CL_BTST) begin
            carry <= bit_bus.tested;
            taken <= (bit_bus.tested == opcode[`BBD_POL_BIT]);
         end
         if (phase == BBD_PH_END && cls == BBD_CL_RETURN_FROM_INTERRUPT) begin
            zero <= return_from_interrupt_flags_in[0];
            carry <= return_from_interrupt_flags_in[1];
         end
      end
   end

   // read-modify-write of the addressed byte, one write pulse
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         ds_we_out <= 1'b0;
         ds_wdata_out <= 8'h00;
      end else begin
         ds_we_out <= (phase == BBD_PH_MEM && cls == BBD_CL_BITOP);
         if (phase == BBD_PH_MEM && cls == BBD_CL_BITOP) ds_wdata_out <= bit_bus.result;
      end
   end

   // return stack; overflow drops the push, underflow falls through
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         sp <= 3'd0;
      end else if (phase == BBD_PH_MEM && cls == BBD_CL_CALL && sp != `BBD_SP_TOP) begin
         stack[sp] <= pc + `BBD_LEN_EXT;
         sp <= sp + 3'd1;
      end else if (phase == BBD_PH_END && (cls == BBD_CL_RET || cls == BBD_CL_RETURN_FROM_INTERRUPT) && sp != 3'd0) begin
         sp <= sp - 3'd1;
      end
   end

   // status outputs
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         done_out <= 1'b0;
         illegal_out <= 1'b0;
         wait_out <= 1'b0;
         stop_out <= 1'b0;
      end else begin
         done_out <= (phase == BBD_PH_END);
         illegal_out <= (phase == BBD_PH_END && cls == BBD_CL_OTHER);
         if (phase == BBD_PH_END && cls == BBD_CL_WAIT) begin
            wait_out <= 1'b1;
         end else if (phase == BBD_PH_END && cls == BBD_CL_STOP) begin
            wait_out <= watchdog_sel_in;
            stop_out <= !watchdog_sel_in;
         end else if (phase == BBD_PH_HALT && wake_in) begin
            wait_out <= 1'b0;
            stop_out <= 1'b0;
         end
      end
   end

   assign pc_out = pc;
   assign zero_out = zero;
   assign carry_out = carry;

   // helper: cycle index within the instruction
   always_ff @(posedge clk_in) begin
      if (!rst_n_in || phase == BBD_PH_END || phase == BBD_PH_HALT) cyc <= 3'd0;
      else cyc <= cyc + 3'd1;
   end

   chk_short_cycles: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (phase == BBD_PH_END && (cls == BBD_CL_REL || cls == BBD_CL_NOP || cls == BBD_CL_RET)) |-> cyc == 3'd1)
      else $error("short instruction not two cycles");
   chk_rel_flags: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (phase == BBD_PH_OP && first_cls == BBD_CL_REL) |=> ##1 (zero == $past(zero, 2) && carry == $past(carry, 2)))
      else $error("short branch changed a flag");
   chk_rel_target: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (phase == BBD_PH_END && cls == BBD_CL_REL && rel_cond) |=>
      pc == $past(pc) + {{7{$past(opcode[7])}}, $past(opcode[7:3])} + 12'h001)
      else $error("short branch target wrong");
   chk_fall_through: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (phase == BBD_PH_END && cls == BBD_CL_REL && !rel_cond) |=> pc == $past(pc) + 12'h001)
      else $error("untaken branch did not continue");
   chk_btst_cycles: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (phase == BBD_PH_END && cls == BBD_CL_BTST) |-> cyc == 3'd4 && zero == $past(zero, 4))
      else $error("bit test length or zero flag wrong");
   chk_btst_target: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (phase == BBD_PH_END && cls == BBD_CL_BTST) |=>
      pc == ($past(taken) ? $past(pc) + {{4{$past(disp[7])}}, $past(disp)} + 12'h002 : $past(pc) + 12'h003))
      else $error("bit test target wrong");
   chk_bitop_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (phase == BBD_PH_MEM && cls == BBD_CL_BITOP) |=> ds_we_out && done_out == 1'b0 ##1 !ds_we_out && done_out)
      else $error("bit op write pulse misplaced");
   chk_jump_target: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (phase == BBD_PH_END && (cls == BBD_CL_JUMP || cls == BBD_CL_CALL)) |-> cyc == 3'd3 ##1
      pc == {$past(opcode[7:4]), $past(ds_addr_out)})
      else $error("jump or call wrong target or length");
   chk_stop_as_wait: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (phase == BBD_PH_END && cls == BBD_CL_STOP && watchdog_sel_in) |=> wait_out && !stop_out)
      else $error("stop executed while watchdog selected");
   // checked only in the read cycle of a bit op: the data byte is undefined elsewhere
   chk_single_bit: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (phase == BBD_PH_MEM && cls == BBD_CL_BITOP) |-> (bit_bus.result ^ bit_bus.data) ==
      ((bit_bus.set_mode != bit_bus.data[bit_bus.idx]) ? (8'h01 << bit_bus.idx) : 8'h00))
      else $error("bit unit changed a bit other than the selected one");

endmodule // bbd_core
`default_nettype wire

// [src/bbd_defines.svh]
// opcode fields, cycle counts and reset values of the branch / bit / control decoder
// assumes one core clock; one instruction cycle here is one clk_in period
`ifndef BBD_DEFINES_SVH
`define BBD_DEFINES_SVH

// opcode low-nibble columns
`define BBD_COL_CALL 4'h1
`define BBD_COL_BTST 4'h3
`define BBD_COL_JUMP 4'h9
`define BBD_COL_BITOP 4'hB

// whole control opcodes
`define BBD_OP_NOP 8'h2D
`define BBD_OP_RET 8'hCD
`define BBD_OP_RETURN_FROM_INTERRUPT 8'h4D
`define BBD_OP_STOP 8'h6D
`define BBD_OP_WAIT 8'hED

// field positions
`define BBD_POL_BIT 4
`define BBD_REL_SEL_BIT 1
`define BBD_REL_WANT_BIT 2

// instruction lengths in cycles, minus one (index of the last cycle)
`define BBD_LAST_SHORT 3'd1
`define BBD_LAST_BITOP 3'd3
`define BBD_LAST_JUMP 3'd3
`define BBD_LAST_BTST 3'd4

// instruction lengths in bytes
`define BBD_LEN_REL 12'h001
`define BBD_LEN_EXT 12'h002
`define BBD_LEN_BTST 12'h003

// reset values and stack size
`define BBD_RESET_PC 12'h000
`define BBD_STACK_DEPTH 6
`define BBD_SP_TOP 3'd6

`endif

// [src/bbd_pkg.sv]
// types shared by the decoder core and its test bench
// assumes bbd_defines.svh is on the include path
`default_nettype none
package bbd_pkg;

   typedef enum logic [2:0] {
      BBD_PH_OP = 3'b000,
      BBD_PH_B2 = 3'b001,
      BBD_PH_MEM = 3'b011,
      BBD_PH_B3 = 3'b010,
      BBD_PH_END = 3'b110,
      BBD_PH_HALT = 3'b111
   } bbd_phase_e;

   typedef enum logic [3:0] {
      BBD_CL_REL, BBD_CL_BTST, BBD_CL_BITOP, BBD_CL_JUMP, BBD_CL_CALL, BBD_CL_NOP,
      BBD_CL_RET, BBD_CL_RETURN_FROM_INTERRUPT, BBD_CL_STOP, BBD_CL_WAIT, BBD_CL_OTHER
   } bbd_class_e;

   typedef logic [11:0] bbd_addr_t;

endpackage
`default_nettype wire
